// >>> include/serial_host_register_port_defs.svh
// Register addresses, command byte fields and reset values of the serial register port
`ifndef SERIAL_HOST_REGISTER_PORT_DEFS_SVH
`define SERIAL_HOST_REGISTER_PORT_DEFS_SVH

`define ADDR_RX_ALARM_MASK         4'h0
`define ADDR_RX_ALARM_STATUS       4'h1
`define ADDR_BIPOLAR_VIOLATION_CNT 4'h2
`define ADDR_CRC_ERROR_CNT         4'h3
`define ADDR_FRAME_ERROR_CNT       4'h4
`define ADDR_RX_CONTROL            4'h5
`define ADDR_COMMON_CONTROL        4'h6
`define ADDR_TX_CONTROL            4'h7
`define ADDR_IDLE_SLOT_SELECT_1    4'h8
`define ADDR_IDLE_SLOT_SELECT_2    4'h9
`define ADDR_IDLE_SLOT_SELECT_3    4'ha
`define ADDR_IDLE_SLOT_SELECT_4    4'hb
`define ADDR_TX_NATIONAL_INTL_BITS 4'hc
`define ADDR_TX_EXTRA_BITS         4'hd
`define ADDR_LAST                  4'hd
`define REG_COUNT                  14

`define CMD_RW_BIT                 0
`define CMD_ADDR_LSB               1
`define CMD_ADDR_MSB               4
`define CMD_BURST_BIT              7
`define CMD_READ                   1'b1

`define TXC_INTL_SEL_BIT           4
`define TXC_NAT_SEL_BIT            3
`define TXC_EXTRA_SEL_BIT          2
`define NAT_BITS_MSB               4
`define INTL_BIT                   7

`define REG_RESET                  8'h00
`define BIT_LAST                   3'h7

`endif

// >>> include/serial_host_register_port_pkg.sv
// Types shared by the serial register port
package serial_host_register_port_pkg;

    typedef enum logic [1:0] {
        PH_CMD  = 2'b00,
        PH_DATA = 2'b01,
        PH_DONE = 2'b10
    } phase_t;

    typedef struct packed {
        logic [7:0]  rxControl;
        logic [7:0]  commonControl;
        logic [7:0]  txControl;
        logic [31:0] idleSlots;
    } cfg_t;

    typedef struct packed {
        logic       intlEn;
        logic       intlBit;
        logic       natEn;
        logic [4:0] natBits;
        logic       extraEn;
        logic [7:0] extraBits;
    } tx_insert_t;

endpackage

// >>> hdl/serial_host_register_port.sv
// Serial host port giving access to the fourteen control, status and counter registers
`include "serial_host_register_port_defs.svh"

module serial_host_register_port
    import serial_host_register_port_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       srst,
    input  wire logic       sclk,
    input  wire logic       csN,
    input  wire logic       portSerialIn,
    output logic            portSerialOut,
    output logic            portSerialOutEn,
    input  wire logic       portModeStrap,
    input  wire logic [7:0] rxAlarms,
    input  wire logic       bipolarViolation,
    input  wire logic       crcError,
    input  wire logic       frameError,
    output logic            intOutN,
    output logic            intOutEn,
    output cfg_t            cfg,
    output tx_insert_t      txInsert
);

    // ---------------- Serial clock domain ----------------
    phase_t          phase_q;
    logic [2:0]      bitCnt_q;
    logic [7:0]      shift_q;
    logic            isRead_q;
    logic            burst_q;
    logic [3:0]      addr_q;
    logic [7:0]      byteIn;
    logic            byteDone;

    // Held stable between toggles; the register side only samples after the toggle lands
    logic [7:0]      wrData_q   = `REG_RESET;
    logic [3:0]      wrAddr_q   = 4'h0;
    logic            wrToggle_q = 1'b0;

    // ---------------- Register clock domain ----------------
    logic [7:0]      regs_q [`REG_COUNT];
    logic [`REG_COUNT-1:0][7:0] snap_q;
    logic [2:0]      csSync_q;
    logic [2:0]      togSync_q;
    logic [2:0]      strapSync_q;
    logic            csIdle_q;
    logic            togFilt_q;
    logic            strapOn_q;
    logic            wrSeen_q;
    logic            wrFire;
    logic [`REG_COUNT-1:0] wrHit;
    logic [`REG_COUNT-1:0] cntEvent;
    logic [7:0]      rdByte;

    function automatic logic isCounter(input logic [3:0] a);
        return (a == `ADDR_BIPOLAR_VIOLATION_CNT) || (a == `ADDR_CRC_ERROR_CNT) ||
               (a == `ADDR_FRAME_ERROR_CNT);
    endfunction

    assign byteIn   = {portSerialIn, shift_q[7:1]};
    assign byteDone = (bitCnt_q == `BIT_LAST);

    // Chip-select high holds the whole shifter in reset
    always_ff @(posedge sclk or posedge csN) begin
        if (csN) begin
            phase_q  <= PH_CMD;
            bitCnt_q <= 3'h0;
            shift_q  <= 8'h00;
            isRead_q <= 1'b0;
            burst_q  <= 1'b0;
            addr_q   <= 4'h0;
        end else begin
            shift_q <= byteIn;
            unique case (phase_q)
                PH_CMD: begin
                    bitCnt_q <= bitCnt_q + 3'h1;
                    if (byteDone) begin
                        isRead_q <= (byteIn[`CMD_RW_BIT] == `CMD_READ);
                        addr_q   <= byteIn[`CMD_ADDR_MSB:`CMD_ADDR_LSB];
                        burst_q  <= byteIn[`CMD_BURST_BIT] &&
                                    (byteIn[`CMD_ADDR_MSB:`CMD_ADDR_LSB] == 4'h0);
                        phase_q  <= PH_DATA;
                    end
                end
                PH_DATA: begin
                    bitCnt_q <= bitCnt_q + 3'h1;
                    if (byteDone) begin
                        if (burst_q && (addr_q != `ADDR_LAST)) begin
                            addr_q <= addr_q + 4'h1;
                        end else begin
                            phase_q <= PH_DONE;
                        end
                    end
                end
                PH_DONE: begin
                    bitCnt_q <= bitCnt_q;
                end
            endcase
        end
    end

    // Publishes each complete written byte; a torn byte never toggles
    always_ff @(posedge sclk) begin
        if (!csN && (phase_q == PH_DATA) && byteDone && !isRead_q) begin
            wrData_q   <= byteIn;
            wrAddr_q   <= addr_q;
            wrToggle_q <= ~wrToggle_q;
        end
    end

    // Snapshot is frozen while chip-select is low, so it is quasi-static here
    assign rdByte = (addr_q <= `ADDR_LAST) ? snap_q[addr_q] : 8'h00;

    always_ff @(negedge sclk or posedge csN) begin
        if (csN) begin
            portSerialOut   <= 1'b0;
            portSerialOutEn <= 1'b0;
        end else if ((phase_q == PH_DATA) && isRead_q) begin
            portSerialOut   <= rdByte[bitCnt_q];
            portSerialOutEn <= 1'b1;
        end else begin
            portSerialOut   <= 1'b0;
            portSerialOutEn <= 1'b0;
        end
    end

    // ---------------- Crossings into the register clock ----------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            csSync_q    <= 3'b111;
            strapSync_q <= 3'b000;
        end else begin
            csSync_q    <= {csSync_q[1:0], csN};
            strapSync_q <= {strapSync_q[1:0], portModeStrap};
        end
    end

    // A change counts only once the second and third stages agree
    always_ff @(posedge mclk) begin
        if (srst) begin
            csIdle_q  <= 1'b1;
            strapOn_q <= 1'b0;
        end else begin
            if (csSync_q[1] == csSync_q[2]) begin
                csIdle_q <= csSync_q[2];
            end
            if (strapSync_q[1] == strapSync_q[2]) begin
                strapOn_q <= strapSync_q[2];
            end
        end
    end

    // Toggle path keeps tracking through srst, so a toggle from before reset is absorbed
    always_ff @(posedge mclk) begin
        togSync_q <= {togSync_q[1:0], wrToggle_q};
        if (togSync_q[1] == togSync_q[2]) begin
            togFilt_q <= togSync_q[2];
        end
    end

    // Follows the filtered toggle every cycle; the difference is the one-cycle write pulse
    always_ff @(posedge mclk) begin
        wrSeen_q <= togFilt_q;
    end

    assign wrFire = (togFilt_q != wrSeen_q) && strapOn_q;

    always_comb begin
        wrHit    = '0;
        cntEvent = '0;
        for (int i = 0; i < `REG_COUNT; i++) begin
            wrHit[i] = wrFire && (wrAddr_q == 4'(i));
        end
        cntEvent[`ADDR_BIPOLAR_VIOLATION_CNT] = bipolarViolation;
        cntEvent[`ADDR_CRC_ERROR_CNT]         = crcError;
        cntEvent[`ADDR_FRAME_ERROR_CNT]       = frameError;
    end

    // ---------------- Register file ----------------
    // One clock stands in for both line clocks, so common control needs no special path
    always_ff @(posedge mclk) begin
        if (srst) begin
            for (int i = 0; i < `REG_COUNT; i++) begin
                regs_q[i] <= `REG_RESET;
            end
        end else begin
            for (int i = 0; i < `REG_COUNT; i++) begin
                if (4'(i) == `ADDR_RX_ALARM_STATUS) begin
                    regs_q[i] <= rxAlarms;
                end else if (isCounter(4'(i))) begin
                    // Preset and error in one cycle: the error still counts
                    regs_q[i] <= (wrHit[i] ? wrData_q : regs_q[i]) +
                                 {7'h00, cntEvent[i]};
                end else if (wrHit[i]) begin
                    regs_q[i] <= wrData_q;
                end
            end
        end
    end

    // Refreshed only while the port is idle; a read sees values as of chip-select fall
    always_ff @(posedge mclk) begin
        if (srst) begin
            snap_q <= '0;
        end else if (csIdle_q) begin
            for (int i = 0; i < `REG_COUNT; i++) begin
                snap_q[i] <= regs_q[i];
            end
        end
    end

    // ---------------- Interrupt and line-side outputs ----------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            intOutN  <= 1'b0;
            intOutEn <= 1'b0;
        end else begin
            intOutN  <= 1'b0;
            // Mask bit set suppresses that alarm
            intOutEn <= |(regs_q[`ADDR_RX_ALARM_STATUS] &
                          ~regs_q[`ADDR_RX_ALARM_MASK]);
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            txInsert <= '0;
        end else begin
            txInsert.intlEn    <= regs_q[`ADDR_TX_CONTROL][`TXC_INTL_SEL_BIT];
            txInsert.intlBit   <= regs_q[`ADDR_TX_CONTROL][`TXC_INTL_SEL_BIT] &
                                  regs_q[`ADDR_TX_NATIONAL_INTL_BITS][`INTL_BIT];
            txInsert.natEn     <= regs_q[`ADDR_TX_CONTROL][`TXC_NAT_SEL_BIT];
            txInsert.natBits   <= regs_q[`ADDR_TX_CONTROL][`TXC_NAT_SEL_BIT] ?
                                  regs_q[`ADDR_TX_NATIONAL_INTL_BITS][`NAT_BITS_MSB:0] :
                                  5'h00;
            txInsert.extraEn   <= regs_q[`ADDR_TX_CONTROL][`TXC_EXTRA_SEL_BIT];
            txInsert.extraBits <= regs_q[`ADDR_TX_CONTROL][`TXC_EXTRA_SEL_BIT] ?
                                  regs_q[`ADDR_TX_EXTRA_BITS] : 8'h00;
        end
    end

    assign cfg.rxControl     = regs_q[`ADDR_RX_CONTROL];
    assign cfg.commonControl = regs_q[`ADDR_COMMON_CONTROL];
    assign cfg.txControl     = regs_q[`ADDR_TX_CONTROL];
    assign cfg.idleSlots     = {regs_q[`ADDR_IDLE_SLOT_SELECT_4], regs_q[`ADDR_IDLE_SLOT_SELECT_3],
                                regs_q[`ADDR_IDLE_SLOT_SELECT_2], regs_q[`ADDR_IDLE_SLOT_SELECT_1]};

endmodule // serial_host_register_port

// >>> verif/serial_host_register_port_assertions.sv
// Concurrent checks on the serial register port pins
module serial_host_register_port_checker
    import serial_host_register_port_pkg::*;
(
    input wire logic       mclk,
    input wire logic       srst,
    input wire logic       sclk,
    input wire logic       csN,
    input wire logic       portSerialOut,
    input wire logic       portSerialOutEn,
    input wire logic [7:0] rxAlarms,
    input wire logic       intOutN,
    input wire logic       intOutEn,
    input wire cfg_t       cfg,
    input wire tx_insert_t txInsert
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] idleCnt_q;
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    // Writes land a few mclk after the last data edge, so a long idle means no write
    always_ff @(posedge mclk) begin
        if (srst || !csN) idleCnt_q <= 4'h0;
        else if (idleCnt_q != 4'hf) idleCnt_q <= idleCnt_q + 4'h1;
    end
    property p_floatDeselect; csN |-> !portSerialOutEn && !portSerialOut; endproperty
    a_floatDeselect: assert property (p_floatDeselect) else $error("out driven deselected");
    property p_outOnFall; !csN && !$stable(portSerialOut) |-> $fell(sclk); endproperty
    a_outOnFall: assert property (p_outOnFall) else $error("out moved off falling edge");
    property p_enOnFall; $rose(portSerialOutEn) |-> $fell(sclk) && !csN; endproperty
    a_enOnFall: assert property (p_enOnFall) else $error("enable rose off falling edge");
    property p_intLevel; intOutN == 1'b0; endproperty
    a_intLevel: assert property (p_intLevel) else $error("interrupt drive level high");
    property p_intQuiet; rxAlarms == 8'h00 [*3] |-> !intOutEn; endproperty
    a_intQuiet: assert property (p_intQuiet) else $error("interrupt without alarm");
    property p_insEn;
        txInsert.extraEn == $past(cfg.txControl[2]) && txInsert.natEn == $past(cfg.txControl[3])
            && txInsert.intlEn == $past(cfg.txControl[4]);
    endproperty
    a_insEn: assert property (p_insEn) else $error("insert enables wrong");
    property p_insZero;
        (txInsert.extraEn || txInsert.extraBits == 8'h00) && (txInsert.intlEn || !txInsert.intlBit)
            && (txInsert.natEn || txInsert.natBits == 5'h00);
    endproperty
    a_insZero: assert property (p_insZero) else $error("disabled insert not zero");
    property p_noWriteIdle; !$stable(cfg) |-> idleCnt_q < 4'hc; endproperty
    a_noWriteIdle: assert property (p_noWriteIdle) else $error("config changed while idle");
endmodule // serial_host_register_port_checker

bind serial_host_register_port serial_host_register_port_checker u_checker (
    .mclk(mclk), .srst(srst), .sclk(sclk), .csN(csN), .portSerialOut(portSerialOut),
    .portSerialOutEn(portSerialOutEn), .rxAlarms(rxAlarms), .intOutN(intOutN),
    .intOutEn(intOutEn), .cfg(cfg), .txInsert(txInsert));

// >>> verif/host_port_model.sv
// Host controller model driving serial register port frames
module host_port_model (
    output logic      sclk,
    output logic      csN,
    output logic      serialIn,
    input  wire logic serialOut,
    input  wire logic serialOutEn
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] wBuf[14];
    logic [7:0] rBuf[14];
    logic       enSeen;
    initial begin
        sclk = 1'b1;
        csN = 1'b0;
        serialIn = 1'b0;
        enSeen = 1'b0;
        // A real rising edge clears the port's serial state at start-up
        #1 csN = 1'b1;
    end
    // Command, n data bytes, then extra bytes of clocks the port must ignore
    task automatic xfer(input logic [7:0] cmd, input int n, input int extra);
        logic [7:0] sh;
        enSeen = 1'b0;
        csN = 1'b0;
        #20;
        for (int i = -1; i < n + extra; i++) begin
            sh = (i < 0) ? cmd : (i < n) ? wBuf[i] : ~wBuf[0];
            for (int b = 0; b < 8; b++) begin
                sclk = 1'b0;
                serialIn = sh[b];
                #16;
                sclk = 1'b1;
                enSeen = enSeen | serialOutEn;
                if (i >= 0 && i < n) rBuf[i][b] = serialOutEn ? serialOut : 1'bx;
                #16;
            end
        end
        csN = 1'b1;
        // Released line must not keep its last value
        serialIn = ~serialIn;
        #60;
    endtask
endmodule // host_port_model

// >>> verif/serial_host_register_port_tb.sv
// Self-checking bench for the serial register port
module serial_host_register_port_tb
    import serial_host_register_port_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    logic       mclk = 1'b0;
    logic       srst = 1'b1;
    logic       strap = 1'b1;
    logic [7:0] alarms = 8'h00;
    logic [2:0] errPulse = 3'h0;
    logic       sclk, csN, serialIn, serialOut, serialOutEn, intOutN, intOutEn;
    cfg_t       cfg;
    tx_insert_t txInsert;
    int         miscompares = 0;
    int         totalChecks = 0;
    // Open drain with pull-up
    wire        intLine = intOutEn ? intOutN : 1'b1;
    always #5 mclk = ~mclk;
    serial_host_register_port dut (.mclk(mclk), .srst(srst), .sclk(sclk), .csN(csN),
        .portSerialIn(serialIn), .portSerialOut(serialOut), .portSerialOutEn(serialOutEn),
        .portModeStrap(strap), .rxAlarms(alarms), .bipolarViolation(errPulse[0]),
        .crcError(errPulse[1]), .frameError(errPulse[2]), .intOutN(intOutN),
        .intOutEn(intOutEn), .cfg(cfg), .txInsert(txInsert));
    host_port_model host (.sclk(sclk), .csN(csN), .serialIn(serialIn),
        .serialOut(serialOut), .serialOutEn(serialOutEn));
    task automatic check(input string what, input logic [63:0] got, input logic [63:0] exp);
        totalChecks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", totalChecks, miscompares);
        if (miscompares == 0 && totalChecks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    function automatic logic [7:0] cmdOf(input logic rd, input logic [3:0] a, input logic bm);
        return {bm, 2'b00, a, rd};
    endfunction
    function automatic logic [7:0] pat(input int a, input logic [7:0] s);
        return 8'(a * 29) ^ s;
    endfunction
    function automatic logic [7:0] expOf(input int a, input logic [7:0] s);
        return (a == 1) ? alarms : (a > 13) ? 8'h00 : pat(a, s);
    endfunction
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        host.wBuf[0] = d;
        host.xfer(cmdOf(1'b0, a, 1'b0), 1, 0);
    endtask
    task automatic rdChk(input string what, input logic [3:0] a, input logic [7:0] exp);
        host.xfer(cmdOf(1'b1, a, 1'b0), 1, 0);
        check(what, 64'(host.rBuf[0]), 64'(exp));
    endtask
    task automatic t_single();
        alarms = 8'h5a;
        check("cfg reset", 64'(cfg), 64'h0);
        for (int a = 0; a < 16; a++) begin
            wr(4'(a), pat(a, 8'h96));
            check("enable in write", 64'(host.enSeen), 64'h0);
        end
        for (int a = 0; a < 16; a++) begin
            rdChk("single read", 4'(a), expOf(a, 8'h96));
        end
        check("cfg", 64'(cfg), 64'({pat(5, 8'h96), pat(6, 8'h96), pat(7, 8'h96),
            pat(11, 8'h96), pat(10, 8'h96), pat(9, 8'h96), pat(8, 8'h96)}));
        $display("single access test done");
    endtask
    task automatic t_burst();
        for (int i = 0; i < 14; i++) host.wBuf[i] = pat(i, 8'h3c);
        host.xfer(cmdOf(1'b0, 4'h0, 1'b1), 14, 0);
        host.xfer(cmdOf(1'b1, 4'h0, 1'b1), 14, 0);
        for (int i = 0; i < 14; i++) begin
            check("burst read", 64'(host.rBuf[i]), 64'(expOf(i, 8'h3c)));
        end
        // Burst flag with nonzero address moves one register only
        host.wBuf[0] = 8'h11;
        host.wBuf[1] = 8'h22;
        host.xfer(cmdOf(1'b0, 4'h3, 1'b1), 2, 1);
        rdChk("no burst target", 4'h3, 8'h11);
        rdChk("no burst next", 4'h4, pat(4, 8'h3c));
        $display("burst test done");
    endtask
    task automatic t_counters();
        for (int c = 0; c < 3; c++) begin
            wr(4'(c + 2), 8'hfe);
            repeat (c + 2) begin
                @(posedge mclk);
                #1 errPulse[c] = 1'b1;
                @(posedge mclk);
                #1 errPulse[c] = 1'b0;
            end
            rdChk("counter wrap", 4'(c + 2), 8'(c));
        end
        $display("counter test done");
    endtask
    task automatic setAlarm(input logic [7:0] v);
        @(posedge mclk);
        #1 alarms = v;
        repeat (3) @(posedge mclk);
        #1;
    endtask
    task automatic t_interrupt();
        // Mask bit set suppresses: alarm 0 masked, alarm 1 open
        wr(4'h0, 8'h01);
        setAlarm(8'h01);
        check("masked alarm", 64'(intLine), 64'h1);
        setAlarm(8'h02);
        check("open alarm", 64'(intLine), 64'h0);
        rdChk("status", 4'h1, 8'h02);
        setAlarm(8'h00);
        check("alarm gone", 64'(intLine), 64'h1);
        $display("interrupt test done");
    endtask
    task automatic t_insert();
        wr(4'hc, 8'h9f);
        wr(4'hd, 8'h3c);
        wr(4'h7, 8'h1c);
        check("insert on", 64'(txInsert), 64'({3'b111, 5'h1f, 1'b1, 8'h3c}));
        wr(4'h7, 8'h00);
        check("insert off", 64'(txInsert), 64'h0);
        @(posedge mclk);
        #1 strap = 1'b0;
        wr(4'h7, 8'h1c);
        rdChk("strap low", 4'h7, 8'h00);
        @(posedge mclk);
        #1 strap = 1'b1;
        $display("insert and strap test done");
    endtask
    // Last toggle before this reset is the ignored strap-low write; it must not replay
    task automatic t_reset();
        @(posedge mclk);
        #1 srst = 1'b1;
        repeat (4) @(posedge mclk);
        #1 srst = 1'b0;
        repeat (12) @(posedge mclk);
        #1;
        check("cfg after mid reset", 64'(cfg), 64'h0);
        check("insert after mid reset", 64'(txInsert), 64'h0);
        $display("mid-run reset test done");
    endtask
    initial begin
        #200000;
        miscompares++;
        $display("watchdog expired");
        conclude();
    end
    initial begin
        repeat (20) @(posedge mclk);
        #1 srst = 1'b0;
        repeat (8) @(posedge mclk);
        #1;
        t_single();
        t_burst();
        t_counters();
        t_interrupt();
        t_insert();
        t_reset();
        conclude();
    end
endmodule // serial_host_register_port_tb
